// file: verilog/umlc_line_ctrl.sv
`timescale 1ns/100ps
module umlc_line_ctrl
  import umlc_pkg::*;
#(
  parameter logic [15:0] BIT_CYC = 16'(umlc_pkg::UMLC_BIT_CYC)
)
(
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_n_in,
  // software-side controls, same clock
  input  wire logic                      loopback_in,
  input  wire logic                      term_ready_in,
  input  wire logic                      req_send_in,
  input  wire logic [UMLC_DATA_W-1:0]    tx_data_in,
  input  wire logic                      tx_valid_in,
  output logic                           tx_ready_out,
  output logic                           tx_idle_out,
  output logic [UMLC_DATA_W-1:0]         rx_data_out,
  output logic                           rx_valid_out,
  output logic                           rx_frame_err_out,
  // pins
  input  wire logic [1:0]                mode_in,
  output logic                           txd_out,
  input  wire logic                      rxd_in,
  output logic                           diff_tx_out,
  output logic                           diff_tx_oe_out,
  input  wire logic                      diff_rx_in,
  output logic                           term_ready_out,
  output logic                           req_send_out,
  input  wire logic                      dsr_in,
  input  wire logic                      cts_in,
  input  wire logic                      dcd_in,
  input  wire logic                      ri_in,
  // synchronised modem status
  output logic                           dsr_out,
  output logic                           cts_out,
  output logic                           dcd_out,
  output logic                           ri_out,
  output logic                           ri_event_out
);

  logic [UMLC_SY_W-1:0]   sy1_reg, sy2_reg;
  umlc_mode_t             mode;
  logic                   diff_mode;
  logic                   tx_allow;
  logic                   rx_line;
  logic                   accept;

  umlc_state_t            state_reg,  state_next;
  logic [UMLC_CNT_W-1:0]  cnt_reg,    cnt_next;
  logic [UMLC_BIT_W-1:0]  bit_reg,    bit_next;
  logic [UMLC_DATA_W-1:0] shift_reg,  shift_next;
  logic                   line_reg,   line_next;
  logic                   ready_reg,  ready_next;
  logic [1:0]             warm_reg,   warm_next;

  logic                   txd_reg,    txd_next;
  logic                   dtx_reg,    dtx_next;
  logic                   doe_reg,    doe_next;
  logic                   dtr_reg,    dtr_next;
  logic                   rts_reg,    rts_next;
  logic [3:0]             st_reg,     st_next;
  logic                   ri_ev_reg,  ri_ev_next;

  // two flops on every pin input; first stage feeds only the second
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      sy1_reg <= UMLC_SY_RST;
      sy2_reg <= UMLC_SY_RST;
    end
    else
    begin
      sy1_reg <= {mode_in, ri_in, dcd_in, cts_in, dsr_in, diff_rx_in, rxd_in};
      sy2_reg <= sy1_reg;
    end
  end

  // static mode
  // mode is a strap; synchronised once and used as a steady level
  assign mode      = umlc_mode_t'(sy2_reg[UMLC_SY_MODE +: 2]);
  assign diff_mode = (mode == UMLC_MODE_P2P) || (mode == UMLC_MODE_MDRP);

  // rts gates transmit
  // in differential modes a character only starts if the bit was low one edge earlier
  assign tx_allow = !diff_mode || !req_send_in;
  assign accept   = tx_valid_in && ready_reg;

  // multidrop receives only while bit high
  always_comb
  begin
    if (loopback_in)
      rx_line = line_reg;
    else if (mode == UMLC_MODE_SE)
      rx_line = sy2_reg[UMLC_SY_RXD];
    else if (mode == UMLC_MODE_MDRP && !req_send_in)
      rx_line = UMLC_MARK; // own echo on the shared pair is ignored
    else
      rx_line = sy2_reg[UMLC_SY_DRX];
  end

  // transmit sequencer, lsb first, one stop bit
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    line_next  = line_reg;
    unique case (state_reg)
      UMLC_S_IDLE:
      begin
        line_next = UMLC_MARK;
        if (accept)
        begin
          shift_next = tx_data_in;
          cnt_next   = BIT_CYC - 1'b1;
          line_next  = UMLC_SPACE;
          state_next = UMLC_S_START;
        end
      end
      UMLC_S_START:
      begin
        if (cnt_reg != '0)
          cnt_next = cnt_reg - 1'b1;
        else
        begin
          cnt_next   = BIT_CYC - 1'b1;
          bit_next   = '0;
          line_next  = shift_reg[0];
          state_next = UMLC_S_DATA;
        end
      end
      UMLC_S_DATA:
      begin
        if (cnt_reg != '0)
          cnt_next = cnt_reg - 1'b1;
        else
        begin
          cnt_next = BIT_CYC - 1'b1;
          if (bit_reg == UMLC_BIT_W'(UMLC_DATA_W - 1))
          begin
            line_next  = UMLC_MARK;
            state_next = UMLC_S_STOP;
          end
          else
          begin
            shift_next = shift_reg >> 1;
            line_next  = shift_reg[1];
            bit_next   = bit_reg + 1'b1;
          end
        end
      end
      UMLC_S_STOP:
      begin
        if (cnt_reg != '0)
          cnt_next = cnt_reg - 1'b1;
        else
          state_next = UMLC_S_IDLE;
      end
    endcase
    // ready is one flop late, so allow may already have dropped
    // hold until mode settles
    // mode flops show single-ended for two edges after reset, which
    // would let a differential port start with the bit high
    warm_next  = warm_reg[1] ? warm_reg : warm_reg + 2'h1;
    ready_next = (state_next == UMLC_S_IDLE) && tx_allow && warm_reg[1];
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= UMLC_S_IDLE;
      cnt_reg   <= '0;
      bit_reg   <= '0;
      shift_reg <= '0;
      line_reg  <= UMLC_MARK;
      ready_reg <= 1'b0;
      warm_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      line_reg  <= line_next;
      ready_reg <= ready_next;
      warm_reg  <= warm_next;
    end
  end

  // pin drive and modem control, all registered
  always_comb
  begin
    txd_next = (loopback_in || mode != UMLC_MODE_SE) ? UMLC_MARK : line_reg;
    dtx_next = (loopback_in || !diff_mode) ? UMLC_MARK : line_reg;
    doe_next = diff_mode && !req_send_in;
    dtr_next = term_ready_in;
    rts_next = req_send_in;
    st_next  = sy2_reg[UMLC_SY_RI:UMLC_SY_DSR];
    ri_ev_next = sy2_reg[UMLC_SY_RI] != st_reg[3];
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      txd_reg   <= UMLC_MARK;
      dtx_reg   <= UMLC_MARK;
      doe_reg   <= 1'b0;
      dtr_reg   <= 1'b0;
      rts_reg   <= 1'b0;
      st_reg    <= '0;
      ri_ev_reg <= 1'b0;
    end
    else
    begin
      txd_reg   <= txd_next;
      dtx_reg   <= dtx_next;
      doe_reg   <= doe_next;
      dtr_reg   <= dtr_next;
      rts_reg   <= rts_next;
      st_reg    <= st_next;
      ri_ev_reg <= ri_ev_next;
    end
  end

  umlc_rx #(
    .BIT_CYC       (BIT_CYC)
  ) u_rx (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .line_in       (rx_line),
    .data_out      (rx_data_out),
    .valid_out     (rx_valid_out),
    .frame_err_out (rx_frame_err_out)
  );

  assign tx_ready_out   = ready_reg;
  assign tx_idle_out    = line_reg; // current line level, mark when idle
  assign txd_out        = txd_reg;
  assign diff_tx_out    = dtx_reg;
  assign diff_tx_oe_out = doe_reg;
  assign term_ready_out = dtr_reg;
  assign req_send_out   = rts_reg;
  assign dsr_out        = st_reg[0];
  assign cts_out        = st_reg[1];
  assign dcd_out        = st_reg[2];
  assign ri_out         = st_reg[3];
  assign ri_event_out   = ri_ev_reg;

endmodule // umlc_line_ctrl

// file: common/umlc_pkg.sv
package umlc_pkg;

  // core clock and default line rate
  localparam int unsigned UMLC_CLK_HZ  = 100_000_000;
  localparam int unsigned UMLC_BAUD    = 115_200;
  // whole cycles per bit, rounded down
  localparam int unsigned UMLC_BIT_CYC = UMLC_CLK_HZ / UMLC_BAUD;
  localparam int unsigned UMLC_CNT_W   = 16;

  // character framing
  localparam int unsigned UMLC_DATA_W  = 8;
  localparam int unsigned UMLC_BIT_W   = 3;
  localparam logic        UMLC_MARK    = 1'b1;
  localparam logic        UMLC_SPACE   = 1'b0;

  // synchroniser vector layout
  localparam int unsigned UMLC_SY_RXD  = 0;
  localparam int unsigned UMLC_SY_DRX  = 1;
  localparam int unsigned UMLC_SY_DSR  = 2;
  localparam int unsigned UMLC_SY_CTS  = 3;
  localparam int unsigned UMLC_SY_DCD  = 4;
  localparam int unsigned UMLC_SY_RI   = 5;
  localparam int unsigned UMLC_SY_MODE = 6;
  localparam int unsigned UMLC_SY_W    = 8;
  // idle data lines sit at mark, status low, mode single-ended
  localparam logic [7:0]  UMLC_SY_RST  = 8'h03;

  // port line mode
  typedef enum logic [1:0] {
    UMLC_MODE_SE   = 2'b00,
    UMLC_MODE_P2P  = 2'b01,
    UMLC_MODE_MDRP = 2'b10
  } umlc_mode_t;

  // transmitter and receiver sequence states
  typedef enum logic [1:0] {
    UMLC_S_IDLE  = 2'b00,
    UMLC_S_START = 2'b01,
    UMLC_S_DATA  = 2'b10,
    UMLC_S_STOP  = 2'b11
  } umlc_state_t;

endpackage

// file: verilog/umlc_rx.sv
`timescale 1ns/100ps
module umlc_rx
  import umlc_pkg::*;
#(
  parameter logic [15:0] BIT_CYC = 16'(umlc_pkg::UMLC_BIT_CYC)
)
(
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  line_in,
  output logic [UMLC_DATA_W-1:0]     data_out,
  output logic                       valid_out,
  output logic                       frame_err_out
);

  umlc_state_t            state_reg,  state_next;
  logic [UMLC_CNT_W-1:0]  cnt_reg,    cnt_next;
  logic [UMLC_BIT_W-1:0]  bit_reg,    bit_next;
  logic [UMLC_DATA_W-1:0] shift_reg,  shift_next;
  logic [UMLC_DATA_W-1:0] data_reg,   data_next;
  logic                   valid_reg,  valid_next;
  logic                   ferr_reg,   ferr_next;

  // sample mid-bit; start edge checked again at half a bit to skip glitches
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    data_next  = data_reg;
    valid_next = 1'b0;
    ferr_next  = 1'b0;
    unique case (state_reg)
      UMLC_S_IDLE:
      begin
        cnt_next = BIT_CYC >> 1;
        if (line_in == UMLC_SPACE)
          state_next = UMLC_S_START;
      end
      UMLC_S_START:
      begin
        if (cnt_reg != '0)
          cnt_next = cnt_reg - 1'b1;
        else if (line_in == UMLC_SPACE)
        begin
          cnt_next   = BIT_CYC - 1'b1;
          bit_next   = '0;
          state_next = UMLC_S_DATA;
        end
        else
          state_next = UMLC_S_IDLE; // glitch, not a start bit
      end
      UMLC_S_DATA:
      begin
        if (cnt_reg != '0)
          cnt_next = cnt_reg - 1'b1;
        else
        begin
          cnt_next   = BIT_CYC - 1'b1;
          shift_next = {line_in, shift_reg[UMLC_DATA_W-1:1]}; // lsb first
          bit_next   = bit_reg + 1'b1;
          if (bit_reg == UMLC_BIT_W'(UMLC_DATA_W - 1))
            state_next = UMLC_S_STOP;
        end
      end
      UMLC_S_STOP:
      begin
        if (cnt_reg != '0)
          cnt_next = cnt_reg - 1'b1;
        else
        begin
          data_next  = shift_reg;
          valid_next = 1'b1;
          ferr_next  = (line_in != UMLC_MARK);
          state_next = UMLC_S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= UMLC_S_IDLE;
      cnt_reg   <= '0;
      bit_reg   <= '0;
      shift_reg <= '0;
      data_reg  <= '0;
      valid_reg <= 1'b0;
      ferr_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      data_reg  <= data_next;
      valid_reg <= valid_next;
      ferr_reg  <= ferr_next;
    end
  end

  assign data_out      = data_reg;
  assign valid_out     = valid_reg;
  assign frame_err_out = ferr_reg;

endmodule // umlc_rx

// file: testbench/umlc_line_ctrl_chk.sv
`timescale 1ns/100ps
module umlc_line_ctrl_chk
  import umlc_pkg::*;
#(
  parameter logic [15:0] BIT_CYC = 16'(UMLC_BIT_CYC)
)
(
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic       loopback_in,
  input wire logic       term_ready_in,
  input wire logic       req_send_in,
  input wire logic       tx_valid_in,
  input wire logic       tx_ready_out,
  input wire logic [1:0] mode_in,
  input wire logic       txd_out,
  input wire logic       diff_tx_out,
  input wire logic       diff_tx_oe_out,
  input wire logic       term_ready_out,
  input wire logic       req_send_out,
  input wire logic       dsr_in,
  input wire logic       dsr_out
);
  // one domain, checks quiet while reset is low
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // character taken by the handshake
  sequence s_take;
    tx_valid_in && tx_ready_out;
  endsequence
  // three clean edges so the synchronisers hold pin data
  sequence s_sync_up;
    $past(rst_n_in, 3) && $past(rst_n_in, 2) && $past(rst_n_in);
  endsequence
  AST_IDLE_MARK:
    assert property (tx_ready_out |-> txd_out && diff_tx_out)
    else $error("line not at mark while idle");
  AST_LOOP_MARK:
    assert property ($past(loopback_in) && loopback_in |-> txd_out && diff_tx_out)
    else $error("line not at mark in loopback");
  AST_TERM_RDY:
    assert property ($past(rst_n_in) |-> term_ready_out == $past(term_ready_in))
    else $error("terminal ready output wrong");
  AST_REQ_SEND:
    assert property ($past(rst_n_in) |-> req_send_out == $past(req_send_in))
    else $error("request to send output wrong");
  AST_DSR_SYNC:
    assert property (s_sync_up |-> dsr_out == $past(dsr_in, 3))
    else $error("set ready status not three edges late");
  AST_OE_OFF:
    assert property ($past(req_send_in) |-> !diff_tx_oe_out)
    else $error("pair driven while request bit high");
  AST_GATE:
    assert property ($past(req_send_in, 2) && $past(req_send_in)
      && mode_in != UMLC_MODE_SE |-> !tx_ready_out)
    else $error("transmit accepted while request bit high");
  AST_START:
    assert property (s_take |-> ##2 (loopback_in
      || (mode_in == UMLC_MODE_SE ? !txd_out : !diff_tx_out)))
    else $error("start bit not on line two edges after take");
  AST_BUSY:
    assert property (s_take |=> !tx_ready_out [*8])
    else $error("ready came back inside a frame");
endmodule // umlc_line_ctrl_chk

bind umlc_line_ctrl umlc_line_ctrl_chk #(.BIT_CYC(BIT_CYC)) u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .loopback_in(loopback_in), .term_ready_in(term_ready_in),
  .req_send_in(req_send_in), .tx_valid_in(tx_valid_in),
  .tx_ready_out(tx_ready_out), .mode_in(mode_in), .txd_out(txd_out),
  .diff_tx_out(diff_tx_out), .diff_tx_oe_out(diff_tx_oe_out),
  .term_ready_out(term_ready_out), .req_send_out(req_send_out),
  .dsr_in(dsr_in), .dsr_out(dsr_out));

// file: testbench/umlc_modem_model.sv
`timescale 1ns/100ps
module umlc_modem_model
#(
  parameter int unsigned BIT_CYC = 4
)
(
  input  wire logic core_clk_in,
  input  wire logic link_in,
  input  wire logic ring_in,
  input  wire logic rts_in,
  input  wire logic line_in,
  output logic      line_out,
  output logic      dsr_out,
  output logic      cts_out,
  output logic      dcd_out,
  output logic      ri_out
);
  logic [7:0] rx_byte;
  int         rx_cnt;
  assign dsr_out = link_in;
  assign cts_out = link_in & rts_in;
  assign dcd_out = link_in;
  assign ri_out  = ring_in;
  initial line_out = 1'b1;
  // frame sender, line rests at mark between frames
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++)
    begin
      line_out = f[k];
      repeat (BIT_CYC) @(negedge core_clk_in);
    end
  endtask
  // receiver samples mid bit, ignores the stop bit
  initial
  begin
    rx_cnt = 0;
    rx_byte = 8'h00;
    forever
    begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(negedge core_clk_in);
      for (int k = 0; k < 8; k++)
      begin
        repeat (BIT_CYC) @(negedge core_clk_in);
        rx_byte[k] = line_in;
      end
      rx_cnt++;
      repeat (BIT_CYC) @(negedge core_clk_in);
    end
  end
endmodule // umlc_modem_model

// file: testbench/umlc_line_ctrl_tb_top.sv
`timescale 1ns/100ps
module umlc_line_ctrl_tb_top;
  import umlc_pkg::*;
  localparam int BC = 4;
  logic       core_clk_in;
  logic       rst_n_in = 1'b0;
  logic       loopback_in = 1'b0;
  logic       term_ready_in = 1'b0;
  logic       req_send_in = 1'b0;
  logic       tx_valid_in = 1'b0;
  logic [7:0] tx_data_in = 8'h00;
  logic [1:0] mode_in = 2'b00;
  logic       link_up = 1'b0;
  logic       ring = 1'b0;
  logic       mline, mdrx, m_dsr, m_cts, m_dcd, m_ri;
  logic       tx_ready_out, rx_valid_out, rx_frame_err_out, txd_out;
  logic       tx_idle_out;
  logic       diff_tx_out, diff_tx_oe_out, term_ready_out, req_send_out;
  logic       dsr_out, cts_out, dcd_out, ri_out, ri_event_out;
  logic [7:0] rx_data_out;
  int         errors = 0, tests_run = 0, got_cnt = 0, ev_cnt = 0;
  int         fe_cnt = 0, i;

  umlc_line_ctrl #(.BIT_CYC(16'(BC))) uut (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .loopback_in(loopback_in), .term_ready_in(term_ready_in),
    .req_send_in(req_send_in), .tx_data_in(tx_data_in),
    .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
    .tx_idle_out(tx_idle_out), .rx_data_out(rx_data_out),
    .rx_valid_out(rx_valid_out),
    .rx_frame_err_out(rx_frame_err_out), .mode_in(mode_in),
    .txd_out(txd_out), .rxd_in(mdrx), .diff_tx_out(diff_tx_out),
    .diff_tx_oe_out(diff_tx_oe_out), .diff_rx_in(mdrx),
    .term_ready_out(term_ready_out), .req_send_out(req_send_out),
    .dsr_in(m_dsr), .cts_in(m_cts), .dcd_in(m_dcd), .ri_in(m_ri),
    .dsr_out(dsr_out), .cts_out(cts_out), .dcd_out(dcd_out),
    .ri_out(ri_out), .ri_event_out(ri_event_out));
  umlc_modem_model #(.BIT_CYC(BC)) mdm (
    .core_clk_in(core_clk_in), .link_in(link_up), .ring_in(ring),
    .rts_in(req_send_out), .line_in(mline), .line_out(mdrx),
    .dsr_out(m_dsr), .cts_out(m_cts), .dcd_out(m_dcd), .ri_out(m_ri));
  // released pair is biased to mark
  assign mline = (mode_in == UMLC_MODE_SE) ? txd_out
               : (diff_tx_oe_out ? diff_tx_out : 1'b1);
  // 100 MHz clock
  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // pulse counters, sampled on the quiet edge
  always @(negedge core_clk_in)
  begin
    got_cnt += (rx_valid_out === 1'b1);
    fe_cnt += (rx_frame_err_out === 1'b1);
    ev_cnt += (ri_event_out === 1'b1);
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task to(input bit ok);
    if (!ok)
    begin
      errors++;
      $display("FAIL %0t wait ran out", $time);
      end_sim;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task wready;
    for (i = 0; i < 99 && tx_ready_out !== 1'b1; i++) cyc(1);
    to(i < 99);
  endtask
  // mode only moves under reset, it is a strap
  task rst(input logic [1:0] m);
    rst_n_in = 1'b0;
    mode_in = m;
    cyc(8);
    chk({4'h0, tx_idle_out, txd_out, diff_tx_out, diff_tx_oe_out}, 8'h0e);
    rst_n_in = 1'b1;
    cyc(3);
  endtask
  // hold valid until the edge that sees ready
  task put(input logic [7:0] b);
    tx_data_in = b;
    tx_valid_in = 1'b1;
    wready;
    cyc(1);
    tx_valid_in = 1'b0;
  endtask
  task t_modem;
    int n;
    rst(2'b00);
    term_ready_in = 1'b1;
    link_up = 1'b1;
    cyc(6);
    chk({4'h0, term_ready_out, req_send_out, dsr_out, dcd_out}, 8'h0b);
    chk({7'h00, cts_out}, 8'h00);
    req_send_in = 1'b1;
    n = ev_cnt;
    ring = 1'b1;
    cyc(6);
    chk({6'h00, cts_out, ri_out}, 8'h03);
    chk(8'(ev_cnt - n), 8'h01);
    term_ready_in = 1'b0;
    cyc(2);
    chk({6'h00, term_ready_out, req_send_out}, 8'h01);
  endtask
  // send out, then take one in with the request bit high
  task t_link(input logic [1:0] m, input logic [7:0] b);
    int n;
    req_send_in = 1'b0;
    rst(m);
    n = mdm.rx_cnt;
    put(b);
    for (i = 0; i < 99 && mdm.rx_cnt == n; i++) cyc(1);
    to(i < 99);
    chk(mdm.rx_byte, b);
    wready;
    req_send_in = 1'b1;
    cyc(2);
    n = got_cnt;
    mdm.send(~b);
    for (i = 0; i < 20 && got_cnt == n; i++) cyc(1);
    to(i < 20);
    chk(rx_data_out, ~b);
    chk(8'(fe_cnt), 8'h00);
  endtask
  task t_gate;
    int n;
    req_send_in = 1'b1;
    rst(2'b01);
    n = mdm.rx_cnt;
    tx_data_in = 8'h0f;
    tx_valid_in = 1'b1;
    cyc(3 * BC);
    chk({6'h00, tx_ready_out, diff_tx_out}, 8'h01);
    tx_valid_in = 1'b0;
    cyc(BC);
    chk(8'(mdm.rx_cnt - n), 8'h00);
  endtask
  // multidrop talking: incoming frames are not heard
  task t_deaf;
    int n;
    req_send_in = 1'b0;
    rst(2'b10);
    n = got_cnt;
    mdm.send(8'h5a);
    cyc(4 * BC);
    chk(8'(got_cnt - n), 8'h00);
  endtask
  task t_loop;
    int n;
    loopback_in = 1'b1;
    rst(2'b00);
    n = got_cnt;
    put(8'h81);
    for (i = 0; i < 99 && got_cnt == n; i++) cyc(1);
    to(i < 99);
    chk(rx_data_out, 8'h81);
    chk({7'h00, txd_out}, 8'h01);
    loopback_in = 1'b0;
  endtask
  initial
  begin
    t_modem;
    t_link(2'b00, 8'ha5);
    t_link(2'b01, 8'h3c);
    t_link(2'b10, 8'hc3);
    t_gate;
    t_deaf;
    t_loop;
    end_sim;
  end
endmodule // umlc_line_ctrl_tb_top
